// ---- shared/emd_regs.svh ----
// Purpose: constants for the external memory decode block
// Assumes: 40 MHz system clock, word addresses in hexadecimal
// Notes:   definitions only
`ifndef EMD_REGS_SVH
`define EMD_REGS_SVH

// memory map bounds (word addresses)
`define EMD_P_EXT_LO     16'h0200
`define EMD_P_EXT_HI     16'h1fff
`define EMD_X_EXT_LO     16'h0100
`define EMD_X_EXT_HI     16'h1fff
`define EMD_Y_EXT_LO     16'h0100
`define EMD_Y_EXT_HI     16'h3fff

// partition sizes in words
`define EMD_P_WORDS      16'h2000
`define EMD_X_WORDS      16'h2000
`define EMD_Y_WORDS      16'h4000

// ram geometry: three 32k x 8 devices
`define EMD_RAM_LANES    3
`define EMD_RAM_ABITS    15

// ram address bases inside the shared array
`define EMD_RAM_BASE_Y   15'h0000
`define EMD_RAM_BASE_X   15'h4000
`define EMD_RAM_BASE_P   15'h6000

// write strobe timing
`define EMD_CLK_MHZ      40
`define EMD_WR_HOLD_NS   15
`define EMD_WR_CYC  ((`EMD_WR_HOLD_NS*`EMD_CLK_MHZ+999)/1000)

// boot memory timing
`define EMD_BOOT_WAITS   15
`define EMD_BOOT_ACC_NS  1000
`define EMD_BOOT_CYC  ((`EMD_BOOT_ACC_NS*`EMD_CLK_MHZ+999)/1000)
`define EMD_BOOT_WORDS   16'h0200
`define EMD_FLASH_BLOCK  64

`endif

// ---- shared/emd_pkg.sv ----
// Purpose: types for the external memory decode block
// Assumes: emd_regs.svh constants
// Notes:   bus groups travel as packed structs
package emd_pkg;

    typedef enum logic [1:0] {
        EMD_SP_NONE,
        EMD_SP_P,
        EMD_SP_X,
        EMD_SP_Y
    } emd_space_t;

    // processor side request
    typedef struct packed {
        logic        prog_strobe;   // program_space_strobe, high active
        logic        data_strobe;   // data_space_strobe, high active
        logic        y_sel;         // data partition select, 1 = y
        logic        wr;            // write request
        logic        rd;            // read request
        logic [15:0] addr;
        logic [23:0] wdata;
    } emd_cpu_t;

    // static ram side
    typedef struct packed {
        logic        cs;
        logic        we;
        logic        oe;
        logic [14:0] addr;
        logic [23:0] wdata;
    } emd_ram_t;

    // boot memory side
    typedef struct packed {
        logic        cs;
        logic        oe;
        logic [14:0] addr;
    } emd_boot_t;

    typedef enum {
        EMD_BOOT_LOAD,
        EMD_BOOT_WAIT,
        EMD_BOOT_RUN
    } emd_bstate_t;

endpackage : emd_pkg

// ---- design/emd_wr_stretch.sv ----
// Purpose: lengthens the ram write strobe to a minimum window
// Assumes: write request is synchronous to clk_sys
// Notes:   strobe stays high at least EMD_WR_CYC cycles
`timescale 1ns/1ps
`include "emd_regs.svh"

module emd_wr_stretch (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // request and stretched strobe
    input  wire logic wr_req,
    output logic      wr_out
);
    import emd_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
    } emd_ws_state_t;

    emd_ws_state_t st;
    emd_ws_state_t next_st;

    localparam logic [3:0] WR_CYC = 4'(`EMD_WR_CYC);

    // reload on request, count down afterwards
    always_comb begin
        next_st = st;
        if (wr_req) begin
            next_st.cnt = WR_CYC;
        end else if (st.cnt != 4'h0) begin
            next_st.cnt = st.cnt - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wr_out = wr_req | (st.cnt != 4'h0);

endmodule : emd_wr_stretch

// ---- design/emd_decode.sv ----
// Purpose: external memory decode between processor port and memories
// Assumes: requests are synchronous to clk_sys, boot memory is slow
// Notes:   ram is three byte lanes forming one 24-bit word
//
// Overview of operation
// - hex map: p, x, y external ranges
// - ram enabled only on space strobes
// - x 8 kW, y 16 kW, p 8 kW
// - three 32k by 8 rams side by side
// - write strobe held one extra 25 ns cycle to cover 15 ns
// - after reset copy boot memory, then run
// - boot reads take 15 wait states
`timescale 1ns/1ps
`include "emd_regs.svh"

module emd_decode (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    // processor port
    input  wire emd_pkg::emd_cpu_t cpu,
    output logic                 cpu_ready,
    output logic [23:0]          cpu_rdata,
    output logic                 boot_busy,
    output logic                 ext_hit,
    // static ram lanes
    output emd_pkg::emd_ram_t    ram,
    output logic [2:0]           ram_lane_cs,
    input  wire logic [23:0]     ram_rdata,
    // boot memory
    output emd_pkg::emd_boot_t   boot,
    input  wire logic [7:0]      boot_rdata,
    // internal program memory load port
    output logic                 load_we,
    output logic [15:0]          load_addr,
    output logic [23:0]          load_data
);
    import emd_pkg::*;

    typedef struct packed {
        emd_bstate_t bst;
        logic [4:0]  wait_cnt;
        logic [1:0]  byte_idx;
        logic [15:0] word_idx;
        logic [23:0] asm_word;
        logic        load_we;
        logic [15:0] load_addr;
        logic [23:0] load_data;
        logic [23:0] rdata;
        logic        ready;
    } emd_st_t;

    emd_st_t st;
    emd_st_t next_st;

    localparam logic [4:0] BOOT_WAITS = 5'(`EMD_BOOT_WAITS);

    // classify an address and strobe pair into a space
    function automatic emd_space_t emd_classify(input emd_cpu_t c);
        emd_space_t s;
        s = EMD_SP_NONE;
        if (c.prog_strobe && c.addr >= `EMD_P_EXT_LO
            && c.addr <= `EMD_P_EXT_HI) begin
            s = EMD_SP_P;
        end else if (c.data_strobe && !c.y_sel
            && c.addr >= `EMD_X_EXT_LO && c.addr <= `EMD_X_EXT_HI) begin
            s = EMD_SP_X;
        end else if (c.data_strobe && c.y_sel
            && c.addr >= `EMD_Y_EXT_LO && c.addr <= `EMD_Y_EXT_HI) begin
            s = EMD_SP_Y;
        end
        return s;
    endfunction : emd_classify

    function automatic logic [14:0] emd_ram_addr(input emd_space_t s,
                                                 input logic [15:0] a);
        logic [14:0] r;
        r = 15'h0000;
        unique case (s)
            EMD_SP_Y:    r = `EMD_RAM_BASE_Y | {1'b0, a[13:0]};
            EMD_SP_X:    r = `EMD_RAM_BASE_X | {2'b00, a[12:0]};
            EMD_SP_P:    r = `EMD_RAM_BASE_P | {2'b00, a[12:0]};
            EMD_SP_NONE: r = 15'h0000;
        endcase
        return r;
    endfunction : emd_ram_addr

    emd_space_t space;
    logic       ram_sel;
    logic       wr_long;

    assign space   = emd_classify(cpu);
    assign ram_sel = (space != EMD_SP_NONE) && (st.bst == EMD_BOOT_RUN);

    emd_wr_stretch u_wr (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .wr_req  (ram_sel & cpu.wr),
        .wr_out  (wr_long)
    );

    always_comb begin
        next_st = st;
        next_st.load_we = 1'b0;
        next_st.ready   = 1'b0;
        unique case (st.bst)
            EMD_BOOT_LOAD: begin
                next_st.wait_cnt = BOOT_WAITS;
                next_st.bst      = EMD_BOOT_WAIT;
            end
            EMD_BOOT_WAIT: begin
                if (st.wait_cnt != 5'h00) begin
                    next_st.wait_cnt = st.wait_cnt - 5'h01;
                end else begin
                    // byte 0 is the low byte of the word
                    next_st.asm_word = {boot_rdata, st.asm_word[23:8]};
                    if (st.byte_idx == 2'd2) begin
                        next_st.byte_idx  = 2'd0;
                        next_st.load_we   = 1'b1;
                        next_st.load_addr = st.word_idx;
                        next_st.load_data = {boot_rdata, st.asm_word[23:8]};
                        next_st.word_idx  = st.word_idx + 16'h0001;
                        if (st.word_idx == `EMD_BOOT_WORDS - 16'h0001) begin
                            next_st.bst = EMD_BOOT_RUN;
                        end else begin
                            next_st.bst = EMD_BOOT_LOAD;
                        end
                    end else begin
                        next_st.byte_idx = st.byte_idx + 2'd1;
                        next_st.bst      = EMD_BOOT_LOAD;
                    end
                end
            end
            EMD_BOOT_RUN: begin
                next_st.ready = ram_sel & cpu.rd;
                if (ram_sel & cpu.rd) begin
                    next_st.rdata = ram_rdata;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '{bst: EMD_BOOT_LOAD, default: '0};
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        ram       = '0;
        ram.cs    = ram_sel;
        // a read right after a write must not see the stretched strobe
        ram.we    = wr_long & (st.bst == EMD_BOOT_RUN)
                    & !(ram_sel & cpu.rd);
        ram.oe    = ram_sel & cpu.rd;
        ram.addr  = emd_ram_addr(space, cpu.addr);
        ram.wdata = cpu.wdata;
    end

    genvar g;
    generate
        for (g = 0; g < `EMD_RAM_LANES; g++) begin : g_lane
            assign ram_lane_cs[g] = ram.cs;
        end
    endgenerate

    // boot memory drive, byte address = word * 3 + byte
    always_comb begin
        boot      = '0;
        boot.cs   = (st.bst != EMD_BOOT_RUN);
        boot.oe   = (st.bst != EMD_BOOT_RUN);
        boot.addr = 15'(st.word_idx * 16'h0003 + {14'h0000, st.byte_idx});
    end

    assign cpu_ready = st.ready;
    assign cpu_rdata = st.rdata;
    assign boot_busy = (st.bst != EMD_BOOT_RUN);
    assign ext_hit   = ram_sel;
    assign load_we   = st.load_we;
    assign load_addr = st.load_addr;
    assign load_data = st.load_data;

endmodule : emd_decode

// ---- verification/emd_decode_props.sv ----
// Purpose: port assertions for emd_decode
// Assumes: one clock, sync active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module emd_decode_props (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               nrst,
    // watched ports
    input wire emd_pkg::emd_cpu_t  cpu,
    input wire logic               cpu_ready,
    input wire logic               boot_busy,
    input wire logic               ext_hit,
    input wire emd_pkg::emd_ram_t  ram,
    input wire logic [2:0]         ram_lane_cs,
    input wire emd_pkg::emd_boot_t boot,
    input wire logic               load_we
);
    import emd_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ram select, write strobe, read answer, map, address and boot pacing checks
    strobe_gate_a: assert property (
        !(cpu.prog_strobe || cpu.data_strobe) |-> !ram.cs)
        else $error("ram on without strobe");
    boot_block_a: assert property (
        boot_busy |-> boot.cs && !ram.cs) else $error("ram used in boot");
    lane_cs_a: assert property (
        ram_lane_cs == {3{ram.cs}}) else $error("lane select split");
    wr_long_a: assert property (
        $rose(ram.we) |=> ram.we) else $error("write strobe short");
    rd_ready_a: assert property (
        cpu.rd && ext_hit |=> cpu_ready) else $error("no read answer");
    p_map_a: assert property (
        !boot_busy && cpu.prog_strobe && !cpu.data_strobe
        |-> ext_hit == (cpu.addr inside {[16'h0200:16'h1fff]}))
        else $error("program map wrong");
    y_map_a: assert property (
        !boot_busy && cpu.data_strobe && !cpu.prog_strobe && cpu.y_sel
        |-> ext_hit == (cpu.addr inside {[16'h0100:16'h3fff]}))
        else $error("y map wrong");
    x_map_a: assert property (
        !boot_busy && cpu.data_strobe && !cpu.prog_strobe && !cpu.y_sel
        |-> ext_hit == (cpu.addr inside {[16'h0100:16'h1fff]}))
        else $error("x map wrong");
    p_addr_a: assert property (
        ext_hit && cpu.prog_strobe && !cpu.data_strobe
        |-> ram.addr == {2'b11, cpu.addr[12:0]})
        else $error("program ram address wrong");
    x_addr_a: assert property (
        ext_hit && cpu.data_strobe && !cpu.prog_strobe && !cpu.y_sel
        |-> ram.addr == {2'b10, cpu.addr[12:0]})
        else $error("x ram address wrong");
    y_addr_a: assert property (
        ext_hit && cpu.data_strobe && !cpu.prog_strobe && cpu.y_sel
        |-> ram.addr == {1'b0, cpu.addr[13:0]})
        else $error("y ram address wrong");
    load_gap_a: assert property (
        load_we |=> !load_we [*8]) else $error("boot word too fast");

    // main scenarios seen
    boot_word_c: cover property (load_we);
    read_c: cover property (cpu_ready);
    write_c: cover property (ram.we && ram.cs);
    boot_refuse_c: cover property (boot_busy && cpu.prog_strobe);
endmodule : emd_decode_props

// ---- verification/emd_mem_model.sv ----
// Purpose: static ram lanes and slow boot memory
// Assumes: ram writes on the clk_sys edge
// Notes:   idle data lines show the inverted last value
`timescale 1ns/1ps
module emd_mem_model #(
    parameter int ACC = 12  // boot access in cycles
) (
    // clock
    input wire logic               clk_sys,
    // memory sides
    input wire emd_pkg::emd_ram_t  ram,
    input wire emd_pkg::emd_boot_t boot,
    output logic [23:0]            ram_rdata,
    output logic [7:0]             boot_rdata
);
    import emd_pkg::*;
    logic [23:0] mem [0:32767];
    logic [7:0]  flash [0:32767];
    logic [23:0] rlast = 24'h0;
    logic [7:0]  blast = 8'h0;
    logic [14:0] ba = 15'h0;
    int          age = 0;

    always @(posedge clk_sys) begin
        if (ram.cs && ram.we) mem[ram.addr] <= ram.wdata;
        if (ram.cs && ram.oe) rlast <= ram_rdata;
        if (boot.cs && boot.oe) blast <= boot_rdata;
        age <= (boot.addr == ba) ? age + 1 : 0;
        ba <= boot.addr;
    end

    // boot image programmed in 64 byte blocks
    initial begin
        for (int b = 0; b < 32768; b += 64)
            for (int k = 0; k < 64; k++)
                flash[b+k] = 8'(b+k) ^ 8'((b+k) >> 8);
    end

    always @* begin
        ram_rdata = (ram.cs && ram.oe) ? mem[ram.addr] : ~rlast;
        boot_rdata = (boot.cs && boot.oe && age >= ACC) ?
            flash[boot.addr] : ~blast;
    end
endmodule : emd_mem_model

// ---- verification/tb.sv ----
// Purpose: self-checking bench for emd_decode
// Assumes: inputs change on the falling edge
// Notes:   expectations queued, monitor compares
`timescale 1ns/1ps
module tb;
    import emd_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    emd_cpu_t    cpu = '0;
    emd_ram_t    ram;
    emd_boot_t   boot;
    logic [23:0] cpu_rdata, ram_rdata, load_data;
    logic [15:0] load_addr, a;
    logic [7:0]  boot_rdata;
    logic [2:0]  ram_lane_cs;
    logic        cpu_ready, boot_busy, ext_hit, load_we;
    logic [39:0] lq[$];
    logic [23:0] rq[$];
    logic [23:0] d[4];
    int          error_cnt = 0;
    int          n_compared = 0;
    logic        booted = 1'b0;

    emd_decode u_dut (.clk_sys, .nrst, .cpu, .cpu_ready, .cpu_rdata,
        .boot_busy, .ext_hit, .ram, .ram_lane_cs, .ram_rdata, .boot,
        .boot_rdata, .load_we, .load_addr, .load_data);
    emd_mem_model u_mem (.clk_sys, .ram, .boot, .ram_rdata, .boot_rdata);

    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [7:0] bb(input int n);
        return 8'(n) ^ 8'(n >> 8);
    endfunction : bb

    task automatic note_err(input string m);
        error_cnt++;
        $display("ERROR %0t: %s", $time, m);
    endtask : note_err

    task automatic cmp_load();
        n_compared++;
        if (lq.size() == 0 || {load_addr, load_data} !== lq.pop_front())
            note_err("boot word mismatch");
    endtask : cmp_load

    task automatic cmp_read();
        n_compared++;
        if (rq.size() == 0 || cpu_rdata !== rq.pop_front())
            note_err("read data mismatch");
    endtask : cmp_read

    // expected ram select from the memory map
    function automatic logic hit_exp(input emd_space_t s,
                                     input logic [15:0] ad);
        if (s == EMD_SP_P) return ad inside {[16'h0200:16'h1fff]};
        if (s == EMD_SP_X) return ad inside {[16'h0100:16'h1fff]};
        if (s == EMD_SP_Y) return ad inside {[16'h0100:16'h3fff]};
        return 1'b0;
    endfunction : hit_exp

    task automatic cmp_hit(input logic h);
        n_compared++;
        if (ext_hit !== h || ram_lane_cs !== {3{h}})
            note_err("ram select mismatch");
    endtask : cmp_hit

    // one access cycle, then one idle cycle
    task automatic acc(input emd_space_t s, input logic [15:0] ad,
                       input logic w, input logic e, input logic [23:0] v);
        cpu.prog_strobe = (s == EMD_SP_P);
        cpu.data_strobe = (s == EMD_SP_X) || (s == EMD_SP_Y);
        cpu.y_sel = (s == EMD_SP_Y);
        cpu.wr = w;
        cpu.rd = !w;
        cpu.addr = ad;
        cpu.wdata = v;
        if (e) rq.push_back(v);
        #1;
        cmp_hit(booted && hit_exp(s, ad));
        @(negedge clk_sys);
        cpu = '0;
        @(negedge clk_sys);
    endtask : acc

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // monitor: results against oldest notes
    always @(posedge clk_sys) begin
        #1;
        if (load_we === 1'b1) cmp_load();
        if (cpu_ready === 1'b1) cmp_read();
    end

    // watchdog well beyond boot copy and tests
    initial begin
        #1500000;
        note_err("timeout");
        stop_test();
    end

    // main sequence
    initial begin
        void'($urandom(9));
        for (int n = 0; n < 512; n++)
            lq.push_back({16'(n), bb(3*n+2), bb(3*n+1), bb(3*n)});
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        acc(EMD_SP_P, 16'h0400, 1'b0, 1'b0, 24'h0);
        acc(EMD_SP_Y, 16'h0400, 1'b1, 1'b0, 24'h0);
        for (int i = 0; i < 40000 && boot_busy !== 1'b0; i++)
            @(negedge clk_sys);
        n_compared++;
        if (lq.size() != 0) note_err("boot copy incomplete");
        booted = 1'b1;
        $display("boot copy test done");
        a = 16'h0200 + 16'($urandom_range(0, 16'h1dff));
        for (int s = 1; s < 4; s++) begin
            d[s] = 24'($urandom());
            acc(emd_space_t'(s), a, 1'b1, 1'b0, d[s]);
        end
        for (int s = 1; s < 4; s++)
            acc(emd_space_t'(s), a, 1'b0, 1'b1, d[s]);
        acc(EMD_SP_Y, 16'h3fff, 1'b1, 1'b0, 24'h5a5aa5);
        acc(EMD_SP_Y, 16'h3fff, 1'b0, 1'b1, 24'h5a5aa5);
        $display("space split test done");
        acc(EMD_SP_P, 16'h01ff, 1'b0, 1'b0, 24'h0);
        acc(EMD_SP_X, 16'h2000, 1'b0, 1'b0, 24'h0);
        acc(EMD_SP_Y, 16'h00ff, 1'b0, 1'b0, 24'h0);
        acc(EMD_SP_NONE, a, 1'b0, 1'b0, 24'h0);
        $display("unmapped test done");
        stop_test();
    end
endmodule : tb

bind emd_decode emd_decode_props u_props (.clk_sys, .nrst, .cpu,
    .cpu_ready, .boot_busy, .ext_hit, .ram, .ram_lane_cs, .boot, .load_we);
